/* File: rtl/gcs_consts.svh */
// Named constants for the glitchless clock switch.
// Included by the switch core; it holds definitions only.
`ifndef GCS_CONSTS_SVH
`define GCS_CONSTS_SVH

// Synchroniser width: clock_input_a, clock_input_b, amp_ok_a, amp_ok_b, source_sel, cap.
`define GCS_SYNC_W 6
// Width of the edge counters.
`define GCS_CNT_W 5
// Old-clock falling edges followed before the output is parked low.
`define GCS_DRAIN_FALLS 5'h02
// New-clock rising edges after which a silent old clock counts as stuck.
`define GCS_STUCK_RISES 5'h03
// New-clock falling edges the output stays parked low.
`define GCS_LOW_FALLS 5'h02
// Longest switchover, in new-clock cycles.
`define GCS_SW_MAX_CYC 5'h11
// Counter reset and step values.
`define GCS_CNT_ZERO 5'h00
`define GCS_CNT_ONE 5'h01
// Edges the strap capture waits while the synchroniser still shows reset zeros.
`define GCS_WARM_W 2
`define GCS_WARM_ZERO 2'h0

`endif

/* File: rtl/gcs_pkg.sv */
// Types shared by the glitchless clock switch files.
// Assumes the constants header is included where widths are needed.
package gcs_pkg;

  // Switchover sequence states.
  typedef enum logic [1:0] {
    GCS_FOLLOW,
    GCS_DRAIN,
    GCS_LOW
  } gcs_state_t;

  // Synchronised pin levels, packed in synchroniser bit order.
  typedef struct packed {
    logic cap;
    logic sel;
    logic amp_b;
    logic amp_a;
    logic clk_b;
    logic clk_a;
  } gcs_pins_t;

endpackage : gcs_pkg

/* File: rtl/gcs_sync.sv */
// Two-flop synchroniser, one generate lane per bit.
// Assumes every input bit is asynchronous to clk.
`timescale 1ns/1ns
`include "gcs_consts.svh"

module gcs_sync
  import gcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`GCS_SYNC_W-1:0] d,
  output gcs_pins_t q
);

  logic [`GCS_SYNC_W-1:0] meta_r;
  logic [`GCS_SYNC_W-1:0] stab_r;

  // Each lane: first flop feeds only the second flop.
  genvar i;
  generate
    for (i = 0; i < `GCS_SYNC_W; i++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b0;
          stab_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          stab_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign q = gcs_pins_t'(stab_r);

endmodule : gcs_sync

/* File: rtl/gcs_switch.sv */
// Glitchless two-input clock switch with runt suppression and fail-safe hold.
// Assumes both reference clocks are far slower than clk and are sampled as
// ordinary inputs; amplitude detectors for each input arrive as levels.
//
// Contract
// - With suppression on, a select change never yields a shortened output pulse.
// - Both inputs behave identically; either may be primary.
// - Cap pin tied high disables suppression; output switches immediately.
// - Switchover completes within 17 new-clock cycles.
// - Selected input losing amplitude holds output at last valid level.
// - Follow old clock briefly, park low some new pulses, then follow new.
// - Old clock stuck high: hold high, then low, then follow new.
`timescale 1ns/1ns
`include "gcs_consts.svh"

module gcs_switch
  import gcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clock_input_a,
  input wire logic clock_input_b,
  input wire logic amp_ok_a,
  input wire logic amp_ok_b,
  input wire logic source_sel,
  input wire logic startup_cap_pin,
  output logic clock_out,
  output logic active_b,
  output logic switching,
  output logic suppression_off
);

  gcs_pins_t pin;
  gcs_state_t st_r, st_nxt;
  logic active_r, active_nxt;
  logic out_r, out_nxt;
  logic hold_a_r, hold_a_nxt, hold_b_r, hold_b_nxt;
  logic prev_a_r, prev_a_nxt, prev_b_r, prev_b_nxt;
  logic bypass_r, bypass_nxt, strap_done_r, strap_done_nxt;
  logic [`GCS_WARM_W-1:0] warm_r, warm_nxt;
  logic switching_r, switching_nxt;
  logic [`GCS_CNT_W-1:0] old_cnt_r, old_cnt_nxt, new_cnt_r, new_cnt_nxt;
  logic [`GCS_CNT_W-1:0] sw_cyc_r, sw_cyc_nxt;
  logic eff_a, eff_b, cur, cur_prev, nw, nw_prev, cur_amp;
  logic cur_fall, new_rise, new_fall;

  gcs_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({startup_cap_pin, source_sel, amp_ok_b, amp_ok_a, clock_input_b, clock_input_a}),
    .q(pin)
  );

  // fail-safe hold
  // A dead input is replaced by its last level seen while amplitude was good.
  always_comb begin
    eff_a = pin.amp_a ? pin.clk_a : hold_a_r;
    eff_b = pin.amp_b ? pin.clk_b : hold_b_r;
    hold_a_nxt = eff_a;
    hold_b_nxt = eff_b;
    prev_a_nxt = eff_a;
    prev_b_nxt = eff_b;
  end

  // symmetric selection
  // One active flag picks old and new, so both directions share one path.
  always_comb begin
    cur = active_r ? eff_b : eff_a;
    cur_prev = active_r ? prev_b_r : prev_a_r;
    nw = active_r ? eff_a : eff_b;
    nw_prev = active_r ? prev_a_r : prev_b_r;
    cur_amp = active_r ? pin.amp_b : pin.amp_a;
    cur_fall = cur_prev && !cur;
    new_rise = !nw_prev && nw;
    new_fall = nw_prev && !nw;
  end

  // strap capture
  // The synchroniser shows its reset zeros for two edges, so the strap is
  // taken only once its true level has come through, then frozen for good.
  always_comb begin
    warm_nxt = {warm_r[`GCS_WARM_W-2:0], 1'b1};
    strap_done_nxt = strap_done_r | warm_r[`GCS_WARM_W-1];
    bypass_nxt = strap_done_r ? bypass_r : pin.cap;
  end

  // bounded switchover
  // Switchover sequence and output level; fixed small counts keep it short.
  always_comb begin
    st_nxt = st_r;
    active_nxt = active_r;
    old_cnt_nxt = old_cnt_r;
    new_cnt_nxt = new_cnt_r;
    out_nxt = out_r;
    sw_cyc_nxt = (st_r == GCS_FOLLOW) ? `GCS_CNT_ZERO :
                 (new_rise ? sw_cyc_r + `GCS_CNT_ONE : sw_cyc_r);
    if (bypass_r) begin
      active_nxt = pin.sel;
      out_nxt = pin.sel ? eff_b : eff_a;
      st_nxt = GCS_FOLLOW;
    end else begin
      unique case (st_r)
        GCS_FOLLOW: begin
          out_nxt = cur;
          old_cnt_nxt = `GCS_CNT_ZERO;
          new_cnt_nxt = `GCS_CNT_ZERO;
          if (pin.sel != active_r) begin
            st_nxt = GCS_DRAIN;
          end
        end
        GCS_DRAIN: begin
          out_nxt = cur;
          if (cur_fall) begin
            old_cnt_nxt = old_cnt_r + `GCS_CNT_ONE;
          end
          // stuck timer
          // Any old-clock edge restarts the count, so a running old clock is
          // never cut while high, even at the full 1.25 to 1 ratio.
          if (cur != cur_prev) begin
            new_cnt_nxt = `GCS_CNT_ZERO;
          end else if (new_rise) begin
            new_cnt_nxt = new_cnt_r + `GCS_CNT_ONE;
          end
          if (pin.sel == active_r) begin
            // Select went back before anything was cut; keep the old clock.
            st_nxt = GCS_FOLLOW;
          end else if (cur_fall && old_cnt_r >= `GCS_DRAIN_FALLS - `GCS_CNT_ONE) begin
            st_nxt = GCS_LOW;
            new_cnt_nxt = `GCS_CNT_ZERO;
          end else if (new_rise && cur == cur_prev
                       && new_cnt_r >= `GCS_STUCK_RISES - `GCS_CNT_ONE) begin
            // stuck old clock
            // High or low, the old level has lasted several new periods already.
            st_nxt = GCS_LOW;
            out_nxt = 1'b0;
            new_cnt_nxt = `GCS_CNT_ZERO;
          end
        end
        GCS_LOW: begin
          out_nxt = 1'b0;
          if (new_fall) begin
            new_cnt_nxt = new_cnt_r + `GCS_CNT_ONE;
            if (new_cnt_r >= `GCS_LOW_FALLS - `GCS_CNT_ONE) begin
              // join on low
              // New clock has just fallen, so the first output high is whole.
              st_nxt = GCS_FOLLOW;
              active_nxt = !active_r;
            end
          end
        end
      endcase
    end
    switching_nxt = (st_nxt != GCS_FOLLOW);
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= GCS_FOLLOW;
      active_r <= 1'b0;
      out_r <= 1'b0;
      hold_a_r <= 1'b0;
      hold_b_r <= 1'b0;
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
      bypass_r <= 1'b0;
      strap_done_r <= 1'b0;
      warm_r <= `GCS_WARM_ZERO;
      switching_r <= 1'b0;
      old_cnt_r <= `GCS_CNT_ZERO;
      new_cnt_r <= `GCS_CNT_ZERO;
      sw_cyc_r <= `GCS_CNT_ZERO;
    end else begin
      st_r <= st_nxt;
      active_r <= active_nxt;
      out_r <= out_nxt;
      hold_a_r <= hold_a_nxt;
      hold_b_r <= hold_b_nxt;
      prev_a_r <= prev_a_nxt;
      prev_b_r <= prev_b_nxt;
      bypass_r <= bypass_nxt;
      strap_done_r <= strap_done_nxt;
      warm_r <= warm_nxt;
      switching_r <= switching_nxt;
      old_cnt_r <= old_cnt_nxt;
      new_cnt_r <= new_cnt_nxt;
      sw_cyc_r <= sw_cyc_nxt;
    end
  end

  // Outputs straight from flops; switching is registered from the next state.
  assign clock_out = out_r;
  assign active_b = active_r;
  assign switching = switching_r;
  assign suppression_off = bypass_r;

  // Checks on the switch behaviour.
  // bounded switchover
  sw_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_cyc_r <= `GCS_SW_MAX_CYC) else $error("switchover exceeded its cycle bound");

  bypass_direct_a: assert property (@(posedge clk) disable iff (!rst_n)
    bypass_r |=> out_r == ($past(pin.sel) ? $past(eff_b) : $past(eff_a)))
    else $error("bypass output does not track selected input");

  failsafe_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == GCS_FOLLOW && st_nxt == GCS_FOLLOW && !bypass_r && !cur_amp
     && active_nxt == active_r)[*2] |=> $stable(out_r))
    else $error("output moved while selected input had no amplitude");

  map_a_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == GCS_FOLLOW && !bypass_r && !active_r) |=> out_r == $past(eff_a))
    else $error("input a not followed while selected");

  map_b_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == GCS_FOLLOW && !bypass_r && active_r) |=> out_r == $past(eff_b))
    else $error("input b not followed while selected");

  low_stage_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == GCS_LOW && !bypass_r) |=> !out_r)
    else $error("output not low during park stage");

  rise_source_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!bypass_r && $rose(out_r)) |-> $past(st_r) != GCS_LOW && $past(cur))
    else $error("output rose without its clock rising");

  stuck_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == GCS_DRAIN && !bypass_r && pin.sel != active_r && cur == cur_prev && new_rise
     && new_cnt_r == `GCS_STUCK_RISES - `GCS_CNT_ONE) |=> (st_r == GCS_LOW && !out_r))
    else $error("stuck old clock not parked low");

  sw_a_to_b_c: cover property (@(posedge clk) disable iff (!rst_n)
    st_r == GCS_LOW && active_r == 1'b0 ##[1:200] st_r == GCS_FOLLOW && active_r);
  sw_b_to_a_c: cover property (@(posedge clk) disable iff (!rst_n)
    st_r == GCS_LOW && active_r ##[1:200] st_r == GCS_FOLLOW && !active_r);
  stuck_c: cover property (@(posedge clk) disable iff (!rst_n)
    st_r == GCS_DRAIN && new_cnt_r == `GCS_STUCK_RISES - `GCS_CNT_ONE && new_rise);
  bypass_c: cover property (@(posedge clk) disable iff (!rst_n) bypass_r && $changed(active_r));

endmodule : gcs_switch

/* File: verif/gcs_ref_src.sv */
// Behavioural reference clock source standing in front of the clock switch.
// Assumes clk is the fast system clock; the source toggles on its rising edges.
`timescale 1ns/1ns

module gcs_ref_src (
  input wire logic clk,
  input wire logic run,
  input wire logic [4:0] half,
  output logic q
);
  int cnt = 0;

  initial q = 1'b0;

  // ratio set by bench
  // A stopped source freezes at its present level, which models a stuck clock.
  always @(posedge clk) begin
    if (run) begin
      if (cnt + 1 >= half) begin
        cnt <= 0;
        q <= ~q;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : gcs_ref_src

/* File: verif/gcs_switch_tb.sv */
// Self-checking bench for the glitchless clock switch.
// Assumes two source models and a three-cycle pin-to-output latency.
`timescale 1ns/1ns

module gcs_switch_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic amp_ok_a = 1'b1;
  logic amp_ok_b = 1'b1;
  logic source_sel = 1'b0;
  logic startup_cap_pin = 1'b0;
  logic run_a = 1'b1;
  logic run_b = 1'b1;
  logic [4:0] half_a = 5'h08;
  logic [4:0] half_b = 5'h08;
  logic clock_input_a, clock_input_b, clock_out, active_b, switching, suppression_off;
  logic [2:0] ha = 3'h0;
  logic [2:0] hb = 3'h0;
  logic last = 1'b0;
  logic mon = 1'b0;
  logic lvl;
  int run = 0;
  int cyc = 0;
  int n_errors = 0;
  int check_count = 0;

  gcs_ref_src u_src_a (.clk, .run(run_a), .half(half_a), .q(clock_input_a));
  gcs_ref_src u_src_b (.clk, .run(run_b), .half(half_b), .q(clock_input_b));
  gcs_switch u_dut (.clk, .rst_n, .clock_input_a, .clock_input_b, .amp_ok_a, .amp_ok_b,
    .source_sel, .startup_cap_pin, .clock_out, .active_b, .switching, .suppression_off);

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Pin history, so the model sees what the output should show three edges later.
  always @(posedge clk) begin
    ha <= {ha[1:0], clock_input_a};
    hb <= {hb[1:0], clock_input_b};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // no short pulses
  // A stretched pulse is legal; anything shorter than 8 clk cycles, the shortest half period the bench sets, is not.
  always @(posedge clk) begin
    if (clock_out !== last) begin
      if (mon) chk("pulse_width", run >= 8, 1'b1);
      run <= 1;
      last <= clock_out;
    end else begin
      run <= run + 1;
    end
  end

  task automatic follow(input int n);
    repeat (n) begin
      @(negedge clk);
      chk("clock_out", clock_out, source_sel ? hb[2] : ha[2]);
    end
  endtask : follow

  // Bound is 17 new-clock cycles of at most 20 clk each, plus pin latency.
  task automatic swap(input logic s, output logic lvl0);
    bit seen;
    seen = 0;
    lvl0 = 1'b0;
    @(posedge clk) source_sel <= s;
    repeat (346) begin
      @(negedge clk);
      if (switching === 1'b1 && !seen) lvl0 = clock_out;
      if (switching === 1'b1) seen = 1;
      else if (seen) break;
    end
    chk("switching", seen, 1'b1);
    chk("switch_done", switching, 1'b0);
    chk("active_b", active_b, s);
  endtask : swap

  initial begin
    void'($urandom(96));
    half_a = 5'h08 + 5'($urandom % 3);
    half_b = 5'h08 + 5'($urandom % 3);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("active_b", active_b, 1'b0);
    follow(60);
    mon = 1'b1;
    for (int i = 0; i < 4; i++) begin
      swap(~source_sel, lvl);
      repeat ($urandom % 7) @(posedge clk);
      follow(60);
    end
    while (clock_input_a !== 1'b1) @(posedge clk);
    run_a <= 1'b0;
    repeat (10) @(posedge clk);
    swap(1'b1, lvl);
    chk("stuck_level", lvl, 1'b1);
    follow(60);
    run_a <= 1'b1;
    repeat (30) @(posedge clk);
    swap(1'b0, lvl);
    mon = 1'b0;
    while (clock_input_a !== 1'b0) @(posedge clk);
    while (clock_input_a !== 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
    amp_ok_a <= 1'b0;
    repeat (4) @(posedge clk);
    repeat (30) begin
      @(negedge clk);
      chk("held_level", clock_out, 1'b1);
    end
    @(posedge clk);
    amp_ok_a <= 1'b1;
    startup_cap_pin <= 1'b1;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("suppression_off", suppression_off, 1'b1);
    source_sel <= 1'b1;
    repeat (4) @(posedge clk);
    chk("bypass_idle", switching, 1'b0);
    chk("bypass_sel", active_b, 1'b1);
    follow(60);
    end_sim();
  end
endmodule : gcs_switch_tb
